// >>> src/dbgcmp_pkg.sv
package dbgcmp_pkg;

  localparam int          DBGCMP_ADDR_W    = 17;
  localparam int          DBGCMP_DATA_W    = 8;
  localparam int          DBGCMP_APB_AW    = 12;

  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_COMP_A_HIGH  = 4'h0;
  localparam logic [3:0]  IDX_COMP_A_LOW   = 4'h1;
  localparam logic [3:0]  IDX_COMP_B_HIGH  = 4'h2;
  localparam logic [3:0]  IDX_COMP_B_LOW   = 4'h3;
  localparam logic [3:0]  IDX_COMP_C_HIGH  = 4'h4;
  localparam logic [3:0]  IDX_COMP_C_LOW   = 4'h5;
  localparam logic [3:0]  IDX_TRACE_HIGH   = 4'h6;
  localparam logic [3:0]  IDX_COMP_B_EXT   = 4'h9;
  localparam logic [3:0]  IDX_CTRL         = 4'ha;
  localparam logic [3:0]  IDX_STATUS       = 4'hb;

  localparam logic [7:0]  RST_REG          = 8'h00;

  // Comparator B extension fields
  localparam int          EXT_DIR_EN_BIT   = 7;
  localparam int          EXT_DIR_VAL_BIT  = 6;
  localparam int          EXT_PAGE_BIT     = 5;
  localparam int          EXT_BIT16_BIT    = 0;
  localparam logic [7:0]  EXT_WMASK        = 8'he1;

  // Control fields
  localparam int          CTRL_ENABLE_BIT  = 7;
  localparam int          CTRL_BEGIN_BIT   = 6;
  localparam int          CTRL_FULL_BIT    = 5;
  localparam int          CTRL_A_DIR_EN_BIT  = 3;
  localparam int          CTRL_A_DIR_VAL_BIT = 2;
  localparam logic [7:0]  CTRL_WMASK       = 8'hec;

  // Status fields, write one to clear
  localparam int          STAT_HIT_A_BIT   = 0;
  localparam int          STAT_HIT_B_BIT   = 1;
  localparam int          STAT_HIT_C_BIT   = 2;
  localparam logic [7:0]  STAT_WMASK       = 8'h07;

  localparam logic [16:0] CARE_16          = 17'h0ffff;
  localparam logic [16:0] CARE_17          = 17'h1ffff;

  typedef struct packed {
    logic        valid;
    logic        rw;
    logic        ppage_sel;
    logic [2:0]  ppage;
    logic [16:0] addr;
    logic [7:0]  data;
  } dbgcmp_core_bus_t;

  typedef struct packed {
    logic [16:0] addr_exp;
    logic [16:0] addr_care;
    logic        dir_en;
    logic        dir_val;
    logic        page_en;
    logic        page_val;
    logic        use_data;
    logic [7:0]  data_exp;
  } dbgcmp_cfg_t;

  function automatic logic dbgcmp_masked_eq(input logic [16:0] val,
                                            input logic [16:0] exp,
                                            input logic [16:0] care);
    dbgcmp_masked_eq = ((val ^ exp) & care) == 17'h00000;
  endfunction

endpackage

// >>> src/dbgcmp_top.sv
// Operation
// RL1: Comparator A low bits give required values of address bits 7 to 0.
// RL2: Comparator B high bits give address bits 15 to 8; unused in full mode.
// RL3: Comparator C low bits give required values of address bits 7 to 0.
// RL4: Registers clear on reset, but hold through end-run reset with enable set, begin clear; control and status still clear on every reset.
// RL5: B direction enable adds bus direction to B match; ignored in full mode.
// RL6: B direction value: 0 matches writes, 1 matches reads; used only when enabled.
// RL7: B page select requires paged access (page:addr13..0) at 1, non-paged at 0.
// RL8: In full mode B compares data; page select and bit 16 are ignored.
// RL9: Extension bit 0 gives required value of address bit 16 for comparator B.
// RL10: A match needs every enabled qualifier equal in the same bus cycle.
`timescale 1ns/10ps
module dbgcmp_top
  import dbgcmp_pkg::*;
#(
  parameter int APB_AW = DBGCMP_APB_AW
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              power_on_reset,
  input  wire logic              reset_end_run,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core bus being watched
  input  wire dbgcmp_core_bus_t  core_bus,
  // Trace word capture
  input  wire logic              trace_push,
  input  wire logic [15:0]       trace_word,
  // Match flags
  output logic                   match_a,
  output logic                   match_b,
  output logic                   match_c
);

  logic [7:0]  comp_a_addr_high;
  logic [7:0]  comp_a_addr_low;
  logic [7:0]  comp_b_addr_high;
  logic [7:0]  comp_b_addr_low;
  logic [7:0]  comp_c_addr_high;
  logic [7:0]  comp_c_addr_low;
  logic [7:0]  trace_fifo_high;
  logic [7:0]  comp_b_extension;
  logic [7:0]  debug_ctrl;
  logic [7:0]  hit_status;

  logic        keep_on_reset;
  logic        in_reset;
  logic        keep_armed;
  logic        comp_a_enable;
  logic [7:0]  status_clear;
  logic        setup_phase;
  logic        commit;
  logic        do_write;
  logic [3:0]  reg_idx;
  logic        addr_mapped;
  logic [7:0]  read_mux;
  logic [7:0]  wbyte;

  logic        debug_module_enable;
  logic        begin_trigger;
  logic        full_mode;
  logic        comp_a_dir_enable;
  logic        comp_a_dir_value;
  logic        comp_b_dir_enable;
  logic        comp_b_dir_value;
  logic        page_qualify_select;

  dbgcmp_cfg_t cfg_a;
  dbgcmp_cfg_t cfg_b;
  dbgcmp_cfg_t cfg_c;

  // Indices that answer without error
  function automatic logic idx_is_mapped(input logic [3:0] idx);
    if (idx == IDX_COMP_A_HIGH) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_A_LOW) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_B_HIGH) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_B_LOW) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_C_HIGH) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_C_LOW) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_TRACE_HIGH) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_COMP_B_EXT) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_CTRL) begin
      idx_is_mapped = 1'b1;
    end else if (idx == IDX_STATUS) begin
      idx_is_mapped = 1'b1;
    end else begin
      idx_is_mapped = 1'b0;
    end
  endfunction

  // Write strobe for one register index
  function automatic logic wr_sel(input logic wr, input logic [3:0] idx, input logic [3:0] sel);
    wr_sel = wr && (idx == sel);
  endfunction

  // Field views of the control and extension registers
  always_comb begin
    debug_module_enable = debug_ctrl[CTRL_ENABLE_BIT];
    begin_trigger       = debug_ctrl[CTRL_BEGIN_BIT];
    full_mode           = debug_ctrl[CTRL_FULL_BIT];
    comp_a_dir_enable   = debug_ctrl[CTRL_A_DIR_EN_BIT];
    comp_a_dir_value    = debug_ctrl[CTRL_A_DIR_VAL_BIT];
    comp_b_dir_enable   = comp_b_extension[EXT_DIR_EN_BIT];
    comp_b_dir_value    = comp_b_extension[EXT_DIR_VAL_BIT];
    page_qualify_select = comp_b_extension[EXT_PAGE_BIT];
  end

  // Control clears at the first reset edge, so the keep decision is held from there
  always_ff @(posedge clk_sys) begin
    in_reset <= sys_rst;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst && !in_reset) begin
      keep_armed <= debug_module_enable && !begin_trigger; // see RL4
    end
  end

  // Reset that ends a trace run with enable set and begin clear keeps contents
  always_comb begin
    keep_on_reset = reset_end_run && !power_on_reset &&
                    (in_reset ? keep_armed : (debug_module_enable && !begin_trigger)); // see RL4
  end

  // Comparator A is taken over by B in full mode
  always_comb begin
    comp_a_enable = debug_module_enable && !full_mode;
  end

  // APB decode
  always_comb begin
    reg_idx     = paddr[5:2];
    addr_mapped = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      addr_mapped = 1'b0;
    end else if (paddr[APB_AW-1:6] != '0) begin
      addr_mapped = 1'b0;
    end else begin
      addr_mapped = idx_is_mapped(reg_idx);
    end
    setup_phase = psel && !penable;
    commit      = psel && penable && pready;
    do_write    = commit && pwrite && addr_mapped;
    wbyte       = pwdata[7:0];
  end

  always_comb begin
    read_mux = 8'h00;
    if (reg_idx == IDX_COMP_A_HIGH) begin
      read_mux = comp_a_addr_high;
    end else if (reg_idx == IDX_COMP_A_LOW) begin
      read_mux = comp_a_addr_low;
    end else if (reg_idx == IDX_COMP_B_HIGH) begin
      read_mux = comp_b_addr_high;
    end else if (reg_idx == IDX_COMP_B_LOW) begin
      read_mux = comp_b_addr_low;
    end else if (reg_idx == IDX_COMP_C_HIGH) begin
      read_mux = comp_c_addr_high;
    end else if (reg_idx == IDX_COMP_C_LOW) begin
      read_mux = comp_c_addr_low;
    end else if (reg_idx == IDX_TRACE_HIGH) begin
      read_mux = trace_fifo_high;
    end else if (reg_idx == IDX_COMP_B_EXT) begin
      read_mux = comp_b_extension & EXT_WMASK;
    end else if (reg_idx == IDX_CTRL) begin
      read_mux = debug_ctrl & CTRL_WMASK;
    end else if (reg_idx == IDX_STATUS) begin
      read_mux = hit_status & STAT_WMASK;
    end
  end

  // Bus answer: one access cycle, data latched in setup
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (setup_phase) begin
      pready  <= 1'b1;
      pslverr <= !addr_mapped;
      prdata  <= (addr_mapped && !pwrite) ? {24'h000000, read_mux} : 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Comparator A address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      if (!keep_on_reset) begin // see RL4
        comp_a_addr_high <= RST_REG;
        comp_a_addr_low  <= RST_REG;
      end
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_A_HIGH)) begin
      comp_a_addr_high <= wbyte;
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_A_LOW)) begin
      comp_a_addr_low  <= wbyte; // see RL1
    end
  end

  // Comparator B address and extension
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      if (!keep_on_reset) begin // see RL4
        comp_b_addr_high <= RST_REG;
        comp_b_addr_low  <= RST_REG;
        comp_b_extension <= RST_REG;
      end else begin
        comp_b_extension <= comp_b_extension & EXT_WMASK;
      end
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_B_HIGH)) begin
      comp_b_addr_high <= wbyte; // see RL2
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_B_LOW)) begin
      comp_b_addr_low  <= wbyte;
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_B_EXT)) begin
      comp_b_extension <= wbyte & EXT_WMASK; // see RL9
    end
  end

  // Comparator C address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      if (!keep_on_reset) begin // see RL4
        comp_c_addr_high <= RST_REG;
        comp_c_addr_low  <= RST_REG;
      end
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_C_HIGH)) begin
      comp_c_addr_high <= wbyte;
    end else if (wr_sel(do_write, reg_idx, IDX_COMP_C_LOW)) begin
      comp_c_addr_low  <= wbyte; // see RL3
    end
  end

  // Trace high byte, read only to software
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      if (!keep_on_reset) begin // see RL4
        trace_fifo_high <= RST_REG;
      end
    end else if (trace_push && debug_module_enable) begin
      trace_fifo_high <= trace_word[15:8];
    end
  end

  // Control register clears on every reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      debug_ctrl <= RST_REG;
    end else if (wr_sel(do_write, reg_idx, IDX_CTRL)) begin
      debug_ctrl <= wbyte & CTRL_WMASK;
    end
  end

  // Write one to clear, only the implemented flags
  always_comb begin
    status_clear = 8'h00;
    if (wr_sel(do_write, reg_idx, IDX_STATUS)) begin
      status_clear = wbyte & STAT_WMASK;
    end
  end

  // Sticky hits; a new hit wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hit_status <= RST_REG;
    end else begin
      hit_status <= (hit_status & ~status_clear) | {5'h00, match_c, match_b, match_a};
    end
  end

  // Comparator configurations
  always_comb begin
    cfg_a           = '0;
    cfg_a.addr_exp  = {1'b0, comp_a_addr_high, comp_a_addr_low}; // see RL1
    cfg_a.addr_care = CARE_16;
    cfg_a.dir_en    = comp_a_dir_enable;
    cfg_a.dir_val   = comp_a_dir_value;

    cfg_b = '0;
    if (full_mode) begin
      // Full mode: A address and A direction, B low byte as data
      cfg_b.addr_exp  = cfg_a.addr_exp; // see RL2
      cfg_b.addr_care = CARE_16;
      cfg_b.dir_en    = comp_a_dir_enable; // see RL5 // see RL6
      cfg_b.dir_val   = comp_a_dir_value;
      cfg_b.page_en   = 1'b0; // see RL8
      cfg_b.use_data  = 1'b1; // see RL8
      cfg_b.data_exp  = comp_b_addr_low;
    end else begin
      cfg_b.addr_exp  = {comp_b_extension[EXT_BIT16_BIT], comp_b_addr_high, comp_b_addr_low}; // see RL9 // see RL2
      cfg_b.addr_care = CARE_17;
      cfg_b.dir_en    = comp_b_dir_enable; // see RL5
      cfg_b.dir_val   = comp_b_dir_value; // see RL6
      cfg_b.page_en   = 1'b1; // see RL7
      cfg_b.page_val  = page_qualify_select; // see RL7
    end

    cfg_c           = '0;
    cfg_c.addr_exp  = {1'b0, comp_c_addr_high, comp_c_addr_low}; // see RL3
    cfg_c.addr_care = CARE_16;
  end

  dbgcmp_unit u_comp_a (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .enable  (comp_a_enable),
    .bus     (core_bus),
    .cfg     (cfg_a),
    .hit     (match_a)
  );

  dbgcmp_unit u_comp_b (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .enable  (debug_module_enable),
    .bus     (core_bus),
    .cfg     (cfg_b),
    .hit     (match_b)
  );

  dbgcmp_unit u_comp_c (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .enable  (debug_module_enable),
    .bus     (core_bus),
    .cfg     (cfg_c),
    .hit     (match_c)
  );

endmodule // dbgcmp_top

// >>> src/dbgcmp_unit.sv
`timescale 1ns/10ps
module dbgcmp_unit
  import dbgcmp_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             enable,
  input  wire dbgcmp_core_bus_t bus,
  input  wire dbgcmp_cfg_t      cfg,
  output logic                  hit
);

  logic [16:0] eff_addr;
  logic        addr_ok;
  logic        data_ok;
  logic        dir_ok;
  logic        page_ok;

  // Paged program access forms the address from page and low offset
  always_comb begin
    eff_addr = bus.ppage_sel ? {bus.ppage, bus.addr[13:0]} : bus.addr; // see RL7
    addr_ok  = dbgcmp_masked_eq(eff_addr, cfg.addr_exp, cfg.addr_care); // see RL1 // see RL3 // see RL9
    data_ok  = !cfg.use_data || (bus.data == cfg.data_exp); // see RL8
    dir_ok   = !cfg.dir_en || (bus.rw == cfg.dir_val); // see RL5 // see RL6
    page_ok  = !cfg.page_en || (bus.ppage_sel == cfg.page_val); // see RL7
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hit <= 1'b0;
    end else begin
      hit <= enable && bus.valid && addr_ok && data_ok && dir_ok && page_ok; // see RL10
    end
  end

endmodule // dbgcmp_unit

// >>> test/dbgcmp_core_model.sv
`timescale 1ns/10ps
module dbgcmp_core_model
  import dbgcmp_pkg::*;
(
  input  wire logic       clk_sys,
  output dbgcmp_core_bus_t core_bus
);
  initial core_bus = '0;
  // One bus cycle, then idle with flipped lines so stale values never match
  task automatic cyc(input logic rw, input logic ps, input logic [2:0] pg,
                     input logic [16:0] a, input logic [7:0] d);
    dbgcmp_core_bus_t b;
    b = '{valid: 1'b1, rw: rw, ppage_sel: ps, ppage: pg, addr: a, data: d};
    @(posedge clk_sys);
    core_bus <= b;
    b = ~b;
    b.valid = 1'b0;
    @(posedge clk_sys);
    core_bus <= b;
  endtask
endmodule // dbgcmp_core_model

// >>> test/dbgcmp_monitor.sv
`timescale 1ns/10ps
module dbgcmp_monitor
  import dbgcmp_pkg::*;
#(
  parameter int APB_AW = 12
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire dbgcmp_core_bus_t  core_bus,
  input wire logic              match_a,
  input wire logic              match_b,
  input wire logic              match_c
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  misaligned_err_a: assert property (setup_s ##0 (paddr[1:0] != 2'h0) |=> pslverr) else $error("misaligned ok");
  high_addr_err_a: assert property (setup_s ##0 (|paddr[APB_AW-1:6]) |=> pslverr) else $error("high addr ok");
  hit_a_cause_a: assert property (match_a |-> $past(core_bus.valid)) else $error("a without cycle");
  hit_b_cause_a: assert property (match_b |-> $past(core_bus.valid)) else $error("b without cycle");
  hit_c_cause_a: assert property (match_c |-> $past(core_bus.valid)) else $error("c without cycle");
endmodule // dbgcmp_monitor

bind dbgcmp_top dbgcmp_monitor #(.APB_AW(APB_AW)) u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_bus(core_bus),
  .match_a(match_a), .match_b(match_b), .match_c(match_c)
);

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dbgcmp_pkg::*;
  logic                     clk_sys;
  logic                     sys_rst;
  logic                     power_on_reset;
  logic                     reset_end_run;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [DBGCMP_APB_AW-1:0] paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  dbgcmp_core_bus_t         core_bus;
  logic                     trace_push;
  logic [15:0]              trace_word;
  logic                     match_a;
  logic                     match_b;
  logic                     match_c;
  logic [31:0]              rd;
  logic                     er;
  int                       num_errors = 0;
  int                       checks = 0;
  logic [3:0]               regs [5] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h9};
  logic [11:0]              bad [3] = '{12'h01c, 12'h00d, 12'h400};

  dbgcmp_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .power_on_reset(power_on_reset),
    .reset_end_run(reset_end_run), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_bus(core_bus), .trace_push(trace_push), .trace_word(trace_word),
    .match_a(match_a), .match_b(match_b), .match_c(match_c)
  );
  dbgcmp_core_model core (.clk_sys(clk_sys), .core_bus(core_bus));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [11:0] ba(input logic [3:0] i);
    ba = {6'h00, i, 2'h0};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] i, input logic [7:0] e, input string nm);
    apb(1'b0, ba(i), 8'h00);
    chk(nm, rd, {24'h000000, e});
  endtask

  task automatic hit(input logic rw, input logic ps, input logic [2:0] pg,
                     input logic [16:0] a, input logic [7:0] d, input logic [2:0] e);
    core.cyc(rw, ps, pg, a, d);
    #1;
    chk("match", {29'h0, match_c, match_b, match_a}, {29'h0, e});
  endtask

  task automatic do_reset(input logic p, input logic e);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    power_on_reset <= p;
    reset_end_run <= e;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    power_on_reset <= 1'b0;
    reset_end_run <= 1'b0;
  endtask

  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end

  initial begin
    {sys_rst, power_on_reset, reset_end_run} = 3'b110;
    {psel, penable, pwrite, trace_push} = 4'h0;
    paddr = '0;
    pwdata = 32'h00000000;
    trace_word = 16'h0000;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    power_on_reset <= 1'b0;
    for (int i = 0; i < 5; i++) rdc(regs[i], 8'h00, "reset value");
    apb(1'b1, ba(IDX_COMP_B_EXT), 8'hff);
    rdc(IDX_COMP_B_EXT, EXT_WMASK, "ext mask");
    apb(1'b1, ba(IDX_TRACE_HIGH), 8'h55);
    rdc(IDX_TRACE_HIGH, 8'h00, "trace read only");
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, bad[i], 8'h00);
      chk("slverr", {31'h0, er}, 32'h1);
    end
    for (int i = 0; i < 6; i++) apb(1'b1, ba(i[3:0]), i[0] ? 8'h34 : 8'h12);
    for (int i = 0; i < 6; i++) rdc(i[3:0], i[0] ? 8'h34 : 8'h12, "cmp value");
    apb(1'b1, ba(IDX_COMP_B_EXT), 8'h01);
    apb(1'b1, ba(IDX_CTRL), 8'h80);
    hit(1'b0, 1'b0, 3'h0, 17'h11234, 8'h00, 3'b111);
    hit(1'b0, 1'b0, 3'h0, 17'h01234, 8'h00, 3'b101);
    hit(1'b1, 1'b0, 3'h0, 17'h11235, 8'h00, 3'b000);
    hit(1'b1, 1'b0, 3'h0, 17'h11034, 8'h00, 3'b000);
    apb(1'b1, ba(IDX_COMP_B_EXT), 8'hc1);
    hit(1'b0, 1'b0, 3'h0, 17'h11234, 8'h00, 3'b101);
    hit(1'b1, 1'b0, 3'h0, 17'h11234, 8'h00, 3'b111);
    apb(1'b1, ba(IDX_COMP_B_EXT), 8'h81);
    hit(1'b0, 1'b0, 3'h0, 17'h11234, 8'h00, 3'b111);
    apb(1'b1, ba(IDX_COMP_B_EXT), 8'h21);
    hit(1'b0, 1'b0, 3'h0, 17'h11234, 8'h00, 3'b101);
    hit(1'b0, 1'b1, 3'h4, 17'h0d234, 8'h00, 3'b111);
    @(posedge clk_sys);
    trace_word <= 16'hab00;
    trace_push <= 1'b1;
    @(posedge clk_sys);
    trace_push <= 1'b0;
    rdc(IDX_TRACE_HIGH, 8'hab, "trace capture");
    apb(1'b1, ba(IDX_COMP_B_HIGH), 8'hff);
    apb(1'b1, ba(IDX_CTRL), 8'ha0);
    hit(1'b0, 1'b0, 3'h0, 17'h01234, 8'h34, 3'b110);
    hit(1'b0, 1'b0, 3'h0, 17'h01234, 8'h35, 3'b100);
    apb(1'b1, ba(IDX_CTRL), 8'hac);
    hit(1'b0, 1'b0, 3'h0, 17'h01234, 8'h34, 3'b100);
    hit(1'b1, 1'b0, 3'h0, 17'h01234, 8'h34, 3'b110);
    rdc(IDX_STATUS, 8'h07, "sticky hits");
    apb(1'b1, ba(IDX_STATUS), 8'h05);
    rdc(IDX_STATUS, 8'h02, "hit clear");
    apb(1'b1, ba(IDX_CTRL), 8'h80);
    do_reset(1'b0, 1'b1);
    rdc(IDX_COMP_B_HIGH, 8'hff, "end run keep");
    rdc(IDX_COMP_B_EXT, 8'h21, "end run ext");
    apb(1'b1, ba(IDX_CTRL), 8'hc0);
    do_reset(1'b0, 1'b1);
    rdc(IDX_COMP_B_HIGH, 8'h00, "begin set clear");
    apb(1'b1, ba(IDX_COMP_B_LOW), 8'h77);
    apb(1'b1, ba(IDX_CTRL), 8'h80);
    do_reset(1'b1, 1'b1);
    rdc(IDX_COMP_B_LOW, 8'h00, "power on clear");
    end_of_test();
  end
endmodule // testbench
